/* File: hw/uabd_params.svh */
// Function
// RULE_01 - in auto-baud mode the receive line times the divisor counter over a 55h character
// RULE_02 - setting enable starts calibration; receiver held idle while it runs
// RULE_03 - divisor pair starts counting at the first rising edge after start bit
// RULE_04 - fifth rising edge keeps count, clears enable, sets receive interrupt flag
// RULE_05 - reading receive data register clears the receive interrupt flag
// RULE_06 - during calibration both divisor bytes form one 16-bit counter
// RULE_07 - counter advances at one eighth of the rate generator base clock
// RULE_08 - counter clock from wide and high-speed bits: /32, /128, /128, /512
// RULE_09 - calibration counter starts counting at one
// RULE_10 - software subtracts one from the divisor pair after completion
// RULE_11 - software checks high byte reads 00h for low-byte-only modes
// RULE_12 - with wake enable also set, measure the byte after the break
// RULE_13 - counter overflow before the fifth rising edge sets the overflow flag
// RULE_14 - after overflow keep counting; fifth edge completes as normal
// RULE_15 - software clears the overflow flag by a direct write
// RULE_16 - overflow clear ignored while enable stays set; clear enable first
// RULE_17 - synchronise the receive line and detect edges on the synchronised copy
`ifndef UABD_PARAMS_SVH
`define UABD_PARAMS_SVH

// =====================================================================
// register offsets
`define UABD_OFF_CTRL 8'h00
`define UABD_OFF_DIVL 8'h04
`define UABD_OFF_DIVH 8'h08
`define UABD_OFF_RXDATA 8'h0c
`define UABD_OFF_ISTAT 8'h10
`define UABD_OFF_IMASK 8'h14

// =====================================================================
// baud control fields
`define UABD_CTRL_EN 0
`define UABD_CTRL_OVF 1
`define UABD_CTRL_WAKE 2
`define UABD_CTRL_WIDE 3
`define UABD_CTRL_HS 4
`define UABD_CTRL_RXIF 5
`define UABD_CTRL_BUSY 6

// interrupt status fields
`define UABD_IRQ_DONE 0
`define UABD_IRQ_OVF 1
`define UABD_IRQ_WAKE 2

// =====================================================================
// reset values
`define UABD_RST_CTRL 5'h00
`define UABD_RST_DIV 16'h0000
`define UABD_RST_IMASK 3'h0

// =====================================================================
// timing: base clock dividers of the oscillator and the auto-baud slow-down
`define UABD_BASE_DIV_11 4
`define UABD_BASE_DIV_10 16
`define UABD_BASE_DIV_01 16
`define UABD_BASE_DIV_00 64
`define UABD_SLOW_FACTOR 8
`define UABD_SYNC_EDGES 5

`endif

/* File: hw/uabd_pkg.sv */
`default_nettype none
package uabd_pkg;

	// =====================================================================
	// types
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WAKE = 5'b00010,
		ST_START = 5'b00100,
		ST_FIRST = 5'b01000,
		ST_COUNT = 5'b10000
	} uabd_state_type;

	typedef struct packed {
		logic high_speed_select;
		logic wide_divisor_select;
		logic wake_on_edge_enable;
		logic autobaud_overflow_flag;
		logic autobaud_enable_bit;
	} uabd_ctrl_type;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} uabd_edge_type;

endpackage
`default_nettype wire

/* File: hw/uabd_rxedge.sv */
`default_nettype none
module uabd_rxedge (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic serial_input_line,
	output uabd_pkg::uabd_edge_type edge_o
);

	// =====================================================================
	// synchroniser and edge detect
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	uabd_pkg::uabd_edge_type edge_q;
	uabd_pkg::uabd_edge_type edge_d;

	always_comb begin
		edge_d.level = sync2_q;
		edge_d.rise = sync2_q & ~prev_q; // RULE_17
		edge_d.fall = ~sync2_q & prev_q; // RULE_17
	end

	// idle line is high, so reset to high to avoid a false edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			prev_q <= 1'b1;
			edge_q <= 3'b100;
		end else if (ce) begin
			sync1_q <= serial_input_line; // RULE_17
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			edge_q <= edge_d;
		end
	end

	assign edge_o = edge_q;

endmodule // uabd_rxedge
`default_nettype wire

/* File: hw/uabd_top.sv */
// The address map and register access over AHB-Lite were chosen for this implementation.
`include "uabd_params.svh"
`default_nettype none
module uabd_top #(
	parameter int PRE_W = 9
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic serial_input_line,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	output logic rx_hold_idle
);

	// =====================================================================
	// declarations
	uabd_pkg::uabd_edge_type rx_edge;
	uabd_pkg::uabd_ctrl_type ctrl_q;
	uabd_pkg::uabd_ctrl_type ctrl_d;
	uabd_pkg::uabd_state_type st_q;
	uabd_pkg::uabd_state_type st_d;
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic [16:0] div_inc;
	logic rxif_q;
	logic rxif_d;
	logic [2:0] edges_q;
	logic [2:0] edges_d;
	logic [PRE_W-1:0] pre_q;
	logic [PRE_W-1:0] pre_d;
	logic [PRE_W-1:0] pre_max;
	logic tick;
	logic [2:0] ist_q;
	logic [2:0] ist_d;
	logic [2:0] imask_q;
	logic [2:0] imask_d;
	logic irq_q;
	logic irq_d;
	logic hold_q;
	logic hold_d;
	logic wr_q;
	logic wr_d;
	logic [7:0] wr_off_q;
	logic [7:0] wr_off_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;
	logic hready_q;
	logic acc;
	logic ev_done;
	logic ev_ovf;
	logic ev_wake;
	logic busy;

	// =====================================================================
	// receive line edges
	uabd_rxedge u_rxedge (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.serial_input_line(serial_input_line),
		.edge_o(rx_edge)
	);

	// =====================================================================
	// calibration clock select
	// the base clock is slowed by eight, so the final count is one bit time
	// expressed in full-speed base clock periods
	always_comb begin
		case ({ctrl_q.wide_divisor_select, ctrl_q.high_speed_select}) // RULE_08
			2'b11: pre_max = PRE_W'(`UABD_BASE_DIV_11 * `UABD_SLOW_FACTOR - 1); // RULE_07
			2'b10: pre_max = PRE_W'(`UABD_BASE_DIV_10 * `UABD_SLOW_FACTOR - 1); // RULE_07
			2'b01: pre_max = PRE_W'(`UABD_BASE_DIV_01 * `UABD_SLOW_FACTOR - 1); // RULE_07
			default: pre_max = PRE_W'(`UABD_BASE_DIV_00 * `UABD_SLOW_FACTOR - 1); // RULE_07
		endcase
	end

	assign tick = (pre_q == pre_max);
	assign div_inc = {1'b0, div_q} + 17'h00001;
	assign busy = (st_q != uabd_pkg::ST_IDLE);

	// =====================================================================
	// bus, registers and calibration sequence
	always_comb begin
		ctrl_d = ctrl_q;
		st_d = st_q;
		div_d = div_q;
		rxif_d = rxif_q;
		edges_d = edges_q;
		pre_d = pre_q;
		ist_d = ist_q;
		imask_d = imask_q;
		hrdata_d = hrdata_q;
		ev_done = 1'b0;
		ev_ovf = 1'b0;
		ev_wake = 1'b0;
		acc = hsel & hready & htrans[1];
		wr_d = acc & hwrite;
		wr_off_d = acc ? haddr[7:0] : wr_off_q;

		// read: data is registered in the address phase, side effects go with it
		if (acc && !hwrite) begin
			case (haddr[7:0])
				`UABD_OFF_CTRL: begin
					hrdata_d = 32'h00000000;
					hrdata_d[`UABD_CTRL_EN] = ctrl_q.autobaud_enable_bit;
					hrdata_d[`UABD_CTRL_OVF] = ctrl_q.autobaud_overflow_flag;
					hrdata_d[`UABD_CTRL_WAKE] = ctrl_q.wake_on_edge_enable;
					hrdata_d[`UABD_CTRL_WIDE] = ctrl_q.wide_divisor_select;
					hrdata_d[`UABD_CTRL_HS] = ctrl_q.high_speed_select;
					hrdata_d[`UABD_CTRL_RXIF] = rxif_q;
					hrdata_d[`UABD_CTRL_BUSY] = busy;
				end
				`UABD_OFF_DIVL: hrdata_d = {24'h000000, div_q[7:0]};
				`UABD_OFF_DIVH: hrdata_d = {24'h000000, div_q[15:8]};
				`UABD_OFF_RXDATA: begin
					// no receive datapath here: the byte reads as zero
					hrdata_d = 32'h00000000;
					rxif_d = 1'b0; // RULE_05
				end
				`UABD_OFF_ISTAT: begin
					hrdata_d = {29'h00000000, ist_q};
					ist_d = 3'h0;
				end
				`UABD_OFF_IMASK: hrdata_d = {29'h00000000, imask_q};
				default: hrdata_d = 32'h00000000;
			endcase
		end

		// write: data phase, one cycle after the address was taken
		if (wr_q) begin
			case (wr_off_q)
				`UABD_OFF_CTRL: begin
					ctrl_d.autobaud_enable_bit = hwdata[`UABD_CTRL_EN]; // RULE_02
					ctrl_d.wake_on_edge_enable = hwdata[`UABD_CTRL_WAKE];
					ctrl_d.wide_divisor_select = hwdata[`UABD_CTRL_WIDE];
					ctrl_d.high_speed_select = hwdata[`UABD_CTRL_HS];
					// a clear only counts once enable is already down
					if (!hwdata[`UABD_CTRL_OVF] && !ctrl_q.autobaud_enable_bit) begin // RULE_16
						ctrl_d.autobaud_overflow_flag = 1'b0; // RULE_15
					end
				end
				`UABD_OFF_DIVL: begin
					if (!ctrl_q.autobaud_enable_bit) begin
						div_d[7:0] = hwdata[7:0];
					end
				end
				`UABD_OFF_DIVH: begin
					if (!ctrl_q.autobaud_enable_bit) begin
						div_d[15:8] = hwdata[7:0];
					end
				end
				`UABD_OFF_IMASK: imask_d = hwdata[2:0];
				default: begin
				end
			endcase
		end

		// sequence; hardware sets come after software clears so sets win
		case (st_q)
			uabd_pkg::ST_IDLE: begin
				if (ctrl_q.autobaud_enable_bit) begin // RULE_02
					if (ctrl_q.wake_on_edge_enable) begin
						st_d = uabd_pkg::ST_WAKE; // RULE_12
					end else begin
						st_d = uabd_pkg::ST_START;
					end
				end
			end
			uabd_pkg::ST_WAKE: begin
				// break start wakes, break end releases the measurement
				if (rx_edge.fall) begin
					rxif_d = 1'b1; // RULE_12
					ev_wake = 1'b1;
				end
				if (rx_edge.rise) begin
					ctrl_d.wake_on_edge_enable = 1'b0; // RULE_12
					st_d = uabd_pkg::ST_START;
				end
			end
			uabd_pkg::ST_START: begin
				if (rx_edge.fall) begin
					st_d = uabd_pkg::ST_FIRST;
				end
			end
			uabd_pkg::ST_FIRST: begin
				if (rx_edge.rise) begin // RULE_03
					div_d = 16'h0001; // RULE_09
					pre_d = '0;
					edges_d = 3'h1;
					st_d = uabd_pkg::ST_COUNT; // RULE_01
				end
			end
			uabd_pkg::ST_COUNT: begin
				// line times the counter; both bytes are one counter
				if (tick) begin
					pre_d = '0;
					div_d = div_inc[15:0]; // RULE_06
					if (div_inc[16]) begin // RULE_13
						ctrl_d.autobaud_overflow_flag = 1'b1; // RULE_13
						ev_ovf = 1'b1;
					end
				end else begin
					pre_d = pre_q + PRE_W'(1); // RULE_07
				end
				if (rx_edge.rise) begin
					edges_d = edges_q + 3'h1;
					if (edges_q == 3'(`UABD_SYNC_EDGES - 1)) begin // RULE_04
						// overflowed or not, completion is the same
						ctrl_d.autobaud_enable_bit = 1'b0; // RULE_14
						rxif_d = 1'b1; // RULE_04
						ev_done = 1'b1;
						st_d = uabd_pkg::ST_IDLE;
					end
				end
			end
			default: st_d = uabd_pkg::ST_IDLE;
		endcase

		// abort: enable cleared by software drops the sequence to idle one cycle later
		if (!ctrl_q.autobaud_enable_bit && st_q != uabd_pkg::ST_IDLE) begin // RULE_16
			st_d = uabd_pkg::ST_IDLE;
		end

		if (ev_done) begin
			ist_d[`UABD_IRQ_DONE] = 1'b1;
		end
		if (ev_ovf) begin
			ist_d[`UABD_IRQ_OVF] = 1'b1;
		end
		if (ev_wake) begin
			ist_d[`UABD_IRQ_WAKE] = 1'b1;
		end
		irq_d = |(ist_d & imask_d);
		// the receiver stays idle from the enable write on
		hold_d = ctrl_d.autobaud_enable_bit; // RULE_02
	end

	// =====================================================================
	// registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `UABD_RST_CTRL;
			st_q <= uabd_pkg::ST_IDLE;
			div_q <= `UABD_RST_DIV;
			rxif_q <= 1'b0;
			edges_q <= 3'h0;
			pre_q <= '0;
			ist_q <= 3'h0;
			imask_q <= `UABD_RST_IMASK;
			irq_q <= 1'b0;
			hold_q <= 1'b0;
			wr_q <= 1'b0;
			wr_off_q <= 8'h00;
			hrdata_q <= 32'h00000000;
			hready_q <= 1'b1;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
			st_q <= st_d;
			div_q <= div_d;
			rxif_q <= rxif_d;
			edges_q <= edges_d;
			pre_q <= pre_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			irq_q <= irq_d;
			hold_q <= hold_d;
			wr_q <= wr_d;
			wr_off_q <= wr_off_d;
			hrdata_q <= hrdata_d;
			hready_q <= 1'b1;
		end
	end

	// =====================================================================
	// outputs
	// zero wait states; hresp is a flop held at okay
	logic hresp_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_q <= 1'b0;
		end else if (ce) begin
			hresp_q <= 1'b0;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp = hresp_q;
	assign irq = irq_q;
	assign rx_hold_idle = hold_q;

endmodule // uabd_top
`default_nettype wire

/* File: sim/uabd_assertions.sv */
`default_nettype none
// ========
// checker on the top ports
module uabd_assertions #(
	parameter int PRE_W = 9
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic serial_input_line,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq,
	input wire logic rx_hold_idle
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;
	logic ctl_wr_q, ctl_wr_d, line_q, line_d;
	logic [3:0] rise_q, rise_d, wr_q, wr_d;
	assign take = ce && hsel && hready && htrans[1];
	// saturating ages: only short spans matter, a wide count buys nothing
	always_comb begin
		ctl_wr_d = take && hwrite && haddr[7:0] == 8'h00;
		line_d = serial_input_line;
		rise_d = (serial_input_line && !line_q) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hf};
		wr_d = (take && hwrite) ? 4'h0 : wr_q + {3'h0, wr_q != 4'hf};
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_wr_q <= 1'b0;
			line_q <= 1'b1;
			rise_q <= 4'hf;
			wr_q <= 4'hf;
		end else begin
			ctl_wr_q <= ctl_wr_d;
			line_q <= line_d;
			rise_q <= rise_d;
			wr_q <= wr_d;
		end
	end
	start_hold_a: assert property (ctl_wr_q && hwdata[0] |-> ##[1:2] rx_hold_idle)
		else $error("receiver not held idle after enable");
	abort_release_a: assert property (ctl_wr_q && !hwdata[0] |-> ##[1:2] !rx_hold_idle)
		else $error("receiver still held after enable cleared");
	done_by_edge_a: assert property ($fell(rx_hold_idle) |-> rise_q <= 4'd8 || wr_q <= 4'd4)
		else $error("calibration ended without a line rise");
	irq_cause_a: assert property ($rose(irq) |-> $past(rx_hold_idle) || wr_q <= 4'd3)
		else $error("interrupt raised without an event");
	istat_clear_a: assert property (take && !hwrite && haddr[7:0] == 8'h10 && !rx_hold_idle
		&& !$past(rx_hold_idle) |-> ##[1:2] !irq)
		else $error("interrupt kept after status read");
	rxdata_zero_a: assert property (take && !hwrite && haddr[7:0] == 8'h0c |=> hrdata == 32'h0)
		else $error("receive data read not zero");
	always_ready_a: assert property (hreadyout)
		else $error("wait state inserted");
	okay_resp_a: assert property (!hresp)
		else $error("error response");
	cover property ($fell(rx_hold_idle));
	cover property ($rose(irq));
	cover property (take && !hwrite && haddr[7:0] == 8'h0c);
endmodule // uabd_assertions
bind uabd_top uabd_assertions #(.PRE_W(PRE_W)) u_uabd_chk (
	.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.serial_input_line(serial_input_line), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .irq(irq), .rx_hold_idle(rx_hold_idle)
);
`default_nettype wire

/* File: sim/uabd_sync_tx.sv */
`default_nettype none
// ========
// remote transmitter: optional break, then one frame lsb first
module uabd_sync_tx (
	input wire logic hclk,
	output logic serial_input_line
);
	timeunit 1ns;
	timeprecision 1ns;
	initial serial_input_line = 1'b1;
	task automatic send(input logic [7:0] b, input int t, input int brk);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		if (brk > 0) begin
			serial_input_line <= 1'b0;
			repeat (brk * t) @(posedge hclk);
			serial_input_line <= 1'b1;
			repeat (2 * t) @(posedge hclk);
		end
		for (int i = 0; i < 10; i++) begin
			serial_input_line <= f[i];
			repeat (t) @(posedge hclk);
		end
	endtask
endmodule // uabd_sync_tx
`default_nettype wire

/* File: sim/uart_autobaud_detect_tb.sv */
`include "uabd_params.svh"
`default_nettype none
module uart_autobaud_detect_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, hwrite, line, hreadyout, hresp, irq, hold;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q, rnd;
	logic [7:0] lo;
	int err_count, checks_done, div, t;
	int exp_q[$];
	uabd_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.serial_input_line(line), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq(irq), .rx_hold_idle(hold));
	uabd_sync_tx tx (.hclk(hclk), .serial_input_line(line));
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic end_sim;
		if (err_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// model: count starts at one and gains one per eight base periods
	task automatic cal(input logic [4:0] c, input int brk, input logic [31:0] ist, input logic e);
		bus(1'b1, `UABD_OFF_CTRL, {27'h0, c}, q);
		exp_q.push_back(1 + 8 * t / div);
		#1;
		chk({31'h0, hold}, 32'h1, "hold");
		tx.send(8'h55, t, brk);
		chk({31'h0, irq}, {31'h0, e}, "irq");
		bus(1'b0, `UABD_OFF_CTRL, 32'h0, q);
		chk(q, {26'h0, 1'b1, c[4:3], 3'h0}, "ctrl done");
		bus(1'b0, `UABD_OFF_DIVL, 32'h0, q);
		lo = q[7:0];
		bus(1'b0, `UABD_OFF_DIVH, 32'h0, q);
		chk({16'h0, q[7:0], lo}, exp_q.pop_front(), "divisor");
		chk({16'h0, q[7:0], lo} - 32'h1, 8 * t / div, "bit time");
		if (!c[3]) begin
			chk({24'h0, q[7:0]}, 32'h0, "high byte");
		end
		bus(1'b0, `UABD_OFF_ISTAT, 32'h0, q);
		chk(q, ist, "istat");
		@(posedge hclk);
		#1;
		chk({31'h0, irq}, 32'h0, "irq cleared");
		bus(1'b0, `UABD_OFF_RXDATA, 32'h0, q);
		chk(q, 32'h0, "rxdata");
		bus(1'b0, `UABD_OFF_CTRL, 32'h0, q);
		chk(q, {27'h0, c[4:3], 3'h0}, "ctrl flag cleared");
	endtask
	initial begin
		hresetn = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		rnd = 32'h4541;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, `UABD_OFF_CTRL, 32'h0, q);
		chk(q, 32'h0, "ctrl reset");
		rnd = xs(rnd);
		bus(1'b1, 8'h40, rnd, q);
		bus(1'b0, 8'h40, 32'h0, q);
		chk(q, 32'h0, "unmapped");
		bus(1'b1, `UABD_OFF_DIVL, rnd, q);
		bus(1'b0, `UABD_OFF_DIVL, 32'h0, q);
		chk(q, {24'h0, rnd[7:0]}, "divisor write");
		bus(1'b1, `UABD_OFF_CTRL, 32'h2, q);
		bus(1'b0, `UABD_OFF_CTRL, 32'h0, q);
		chk(q, 32'h0, "overflow write");
		bus(1'b1, `UABD_OFF_CTRL, 32'h1, q);
		bus(1'b1, `UABD_OFF_CTRL, 32'h0, q);
		// the sequence drops to idle one cycle after enable clears
		@(posedge hclk);
		bus(1'b0, `UABD_OFF_CTRL, 32'h0, q);
		chk(q, 32'h0, "abort");
		chk({31'h0, hold}, 32'h0, "hold after abort");
		for (int m = 0; m < 4; m++) begin
			div = m == 3 ? 32 : (m == 0 ? 512 : 128);
			t = 2 * div + div / 16;
			rnd = xs(rnd);
			bus(1'b1, `UABD_OFF_IMASK, {rnd[31:1], m[0]}, q);
			bus(1'b0, `UABD_OFF_IMASK, 32'h0, q);
			chk(q, {29'h0, rnd[2:1], m[0]}, "imask");
			cal({m[0], m[1], 3'b001}, 0, 32'h1, m[0]);
		end
		t = 66;
		div = 32;
		bus(1'b1, `UABD_OFF_IMASK, 32'h5, q);
		cal(5'h1d, 13, 32'h5, 1'b1);
		end_sim;
	end
	// generous ceiling over the roughly 20k cycles the sequence needs
	initial begin
		repeat (60000) @(posedge hclk);
		err_count++;
		end_sim;
	end
endmodule // uart_autobaud_detect_tb
`default_nettype wire
